// [rtl/tdm_frame_timing_defs.vh]
// Constants for the TDM frame-timing front end
`ifndef TDM_FRAME_TIMING_DEFS_VH
`define TDM_FRAME_TIMING_DEFS_VH

// ==================================================================
// Frame geometry
`define FRAME_RATE_HZ       8000
`define MCLK_RATE_HZ        8192000
// Master clock cycles in one 125 us frame
`define FRAME_CYCLES        (`MCLK_RATE_HZ / `FRAME_RATE_HZ)

// ==================================================================
// Pulse widths as printed, in ns
`define MCLK_PERIOD_NS      122
`define PW_NARROW_NS        122
`define PW_WIDE_NS          244
`define FAST_PW_NARROW_NS   61
`define FAST_PW_WIDE_NS     122
// Pulse widths in master clock cycles
`define PW_NARROW_CYC       (`PW_NARROW_NS / `MCLK_PERIOD_NS)
`define PW_WIDE_CYC         (`PW_WIDE_NS / `MCLK_PERIOD_NS)

// ==================================================================
// Style detection and counter widths
`define IDLE_RUN            4'h8
`define CNT_W               11
`define HALF_W              8
`define STYLE_IDLE_RST      1'b1

`endif

// [rtl/tdm_frame_timing_generator.v]
// Frame-timing front end: input frame locate, output clocks and pulses
`timescale 1ns/1ps
// Behaviour
// - Input frame boundary on selected master edge
// - Input pulse width follows width select
// - Frame pulse style detected automatically
// - Slow output clock generated and driven
// - Output boundary on selected slow clock edge
// - Slow output pulse width follows width select
// - Output pulse 8 kHz, same style
// - Fast clock generated, boundary on selected edge
// - Fast pulse half width, 8 kHz repeat
`include "tdm_frame_timing_defs.vh"

module tdm_frame_timing_generator #(
  parameter FRAME_CYCLES = `FRAME_CYCLES // Master cycles per frame
) (
  input  wire REF_CLK_I,                // Block clock
  input  wire RESETN_I,                 // Async reset, active low
  input  wire MASTER_CLOCK_IN_I,        // Master clock pin
  input  wire FRAME_PULSE_IN_I,         // Input frame pulse pin
  input  wire INPUT_EDGE_SELECT_I,      // 1 rising, 0 falling
  input  wire OUTPUT_EDGE_SELECT_I,     // 1 rising, 0 falling
  input  wire FRAME_PULSE_WIDTH_SELECT_I, // 0 narrow, 1 wide
  output reg  SLOW_CLOCK_OUT_O,         // Slow output clock
  output reg  FRAME_PULSE_OUT_O,        // Slow output frame pulse
  output reg  FAST_CLOCK_OUT_O,         // Fast output clock
  output reg  FAST_FRAME_PULSE_OUT_O,   // Fast output frame pulse
  output reg  FRAME_START_O,            // One-cycle boundary strobe
  output reg  STYLE_GCI_O               // Detected style, 1 active high
);

  // ================================================================
  // Synchronisers
  reg  [1:0]  mclk_sync_reg;   // Master clock, two stages
  reg  [1:0]  fp_sync_reg;     // Frame pulse, two stages
  reg  [1:0]  cfg_in_reg;      // Input edge select, two stages
  reg  [1:0]  cfg_out_reg;     // Output edge select, two stages
  reg  [1:0]  cfg_w_reg;       // Width select, two stages
  reg         mclk_prev_reg;   // Last synced master level

  // Only the second stages are read by logic
  always @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mclk_sync_reg <= 2'h0;
      fp_sync_reg   <= {2{`STYLE_IDLE_RST}};
      cfg_in_reg    <= 2'h0;
      cfg_out_reg   <= 2'h0;
      cfg_w_reg     <= 2'h0;
      mclk_prev_reg <= 1'b0;
    end else begin
      mclk_sync_reg <= {mclk_sync_reg[0], MASTER_CLOCK_IN_I};
      fp_sync_reg   <= {fp_sync_reg[0], FRAME_PULSE_IN_I};
      cfg_in_reg    <= {cfg_in_reg[0], INPUT_EDGE_SELECT_I};
      cfg_out_reg   <= {cfg_out_reg[0], OUTPUT_EDGE_SELECT_I};
      cfg_w_reg     <= {cfg_w_reg[0], FRAME_PULSE_WIDTH_SELECT_I};
      mclk_prev_reg <= mclk_sync_reg[1];
    end
  end

  // ================================================================
  // Edge detection
  wire mclk_s    = mclk_sync_reg[1];            // Synced master level
  wire fp_s      = fp_sync_reg[1];              // Synced pulse level
  wire in_sel    = cfg_in_reg[1];               // Input edge choice
  wire out_sel   = cfg_out_reg[1];              // Output edge choice
  wire wide      = cfg_w_reg[1];                // Wide pulse mode
  wire any_edge  = mclk_s ^ mclk_prev_reg;      // Either master edge
  // Selected edge: rising when in_sel, else falling
  wire sel_edge  = any_edge & (mclk_s == in_sel);

  // ================================================================
  // Style detection and boundary location
  reg         idle_level_reg;   // Level the pulse rests at
  reg         last_fp_reg;      // Pulse level at previous edge
  reg  [3:0]  run_reg;          // Consecutive equal samples
  reg         pend_reg;         // Wide mode: boundary one edge later
  reg         boundary;         // Boundary at this selected edge

  // Active sample right after an idle one opens a pulse; shared by
  // the narrow boundary and the wide-mode pending flag
  function first_active;
    input cur;   // Pulse level at this edge
    input prev;  // Pulse level one edge earlier
    input idle;  // Learned idle level
    begin
      first_active = (cur != idle) & (prev == idle);
    end
  endfunction

  // A long run of one level marks the idle level; an idle-high
  // pulse is the native style, idle-low is the GCI style.
  always @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      idle_level_reg <= `STYLE_IDLE_RST;
      last_fp_reg    <= `STYLE_IDLE_RST;
      run_reg        <= 4'h0;
      pend_reg       <= 1'b0;
    end else if (sel_edge) begin
      last_fp_reg <= fp_s;
      if (fp_s != last_fp_reg) begin
        run_reg <= 4'h0;
      end else if (run_reg != `IDLE_RUN) begin
        run_reg <= run_reg + 4'h1;
      end else begin
        idle_level_reg <= fp_s;
      end
      // Wide pulse spans two edges; boundary sits on the second
      pend_reg <= wide
                  & first_active(fp_s, last_fp_reg, idle_level_reg);
    end
  end

  // First active sample, or its successor in wide mode
  always @* begin
    boundary = 1'b0;
    if (sel_edge) begin
      if (wide) begin
        boundary = pend_reg;
      end else begin
        boundary = first_active(fp_s, last_fp_reg, idle_level_reg);
      end
    end
  end

  // ================================================================
  // Frame counter, master cycles since the boundary
  reg  [`CNT_W-1:0] frame_cnt_reg;  // Position in frame
  wire [`CNT_W-1:0] last_cnt = FRAME_CYCLES[`CNT_W-1:0] - 1'b1;
  wire              cnt_last = (frame_cnt_reg == last_cnt); // Final cycle

  // Free-running at 8 kHz, re-aligned on each found boundary
  always @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      frame_cnt_reg <= {`CNT_W{1'b0}};
    end else if (boundary) begin
      frame_cnt_reg <= {`CNT_W{1'b0}};
    end else if (sel_edge) begin
      if (cnt_last) begin
        frame_cnt_reg <= {`CNT_W{1'b0}};
      end else begin
        frame_cnt_reg <= frame_cnt_reg + 1'b1;
      end
    end
  end

  // ================================================================
  // Half-period measurement for the fast clock midpoint
  reg  [`HALF_W-1:0] half_cnt_reg;  // Ref cycles since last edge
  reg  [`HALF_W-1:0] half_len_reg;  // Last measured half-period
  reg                mid_seen_reg;  // Midpoint toggle done
  // The count starts one cycle after the edge, so the midpoint sits
  // one below half the length; before a length is known this is the
  // top value, reached only if the master clock stalls.
  wire [`HALF_W-1:0] mid_point = (half_len_reg >> 1)
                                 - {{(`HALF_W-1){1'b0}},1'b1};
  wire               mid_hit = ~mid_seen_reg & ~any_edge
                       & (half_cnt_reg == mid_point);

  // Midpoint is taken from the previous half-period, so a jump in
  // master frequency skews the fast clock for one half-period only.
  always @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      half_cnt_reg <= {`HALF_W{1'b0}};
      half_len_reg <= {`HALF_W{1'b0}};
      mid_seen_reg <= 1'b0;
    end else if (any_edge) begin
      half_len_reg <= half_cnt_reg + 1'b1;
      half_cnt_reg <= {`HALF_W{1'b0}};
      mid_seen_reg <= 1'b0;
    end else begin
      if (half_cnt_reg != {`HALF_W{1'b1}}) begin
        half_cnt_reg <= half_cnt_reg + 1'b1;
      end
      if (mid_hit) begin
        mid_seen_reg <= 1'b1;
      end
    end
  end

  // ================================================================
  // Output clocks and frame pulses
  // The count moves only at a selected edge, so in that cycle it still
  // shows the old value; the edge cycle goes to the new count so that
  // each pulse lasts whole master periods, not one cycle more.
  wire cnt_zero  = (frame_cnt_reg == {`CNT_W{1'b0}});
  wire cnt_one   = (frame_cnt_reg == {{(`CNT_W-1){1'b0}},1'b1});
  wire frame_beg = boundary | (sel_edge & cnt_last);
  wire at_zero   = frame_beg | (cnt_zero & ~sel_edge);
  wire at_one    = ~boundary & ((cnt_zero & sel_edge)
                                | (cnt_one & ~sel_edge));
  wire in_first = ~any_edge ? (mclk_s == in_sel) : sel_edge;
  reg  slow_act;   // Slow pulse active this cycle
  reg  fast_act;   // Fast pulse active this cycle

  // Slow pulse: one or two master cycles from the boundary;
  // fast pulse: half or one master cycle from the boundary.
  always @* begin
    slow_act = at_zero;
    fast_act = at_zero & in_first;
    if (wide) begin
      slow_act = at_zero | at_one;
      fast_act = at_zero;
    end
  end

  // All outputs registered; boundary edge type chosen by out_sel
  always @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      SLOW_CLOCK_OUT_O       <= 1'b0;
      FAST_CLOCK_OUT_O       <= 1'b0;
      FRAME_PULSE_OUT_O      <= `STYLE_IDLE_RST;
      FAST_FRAME_PULSE_OUT_O <= `STYLE_IDLE_RST;
      FRAME_START_O          <= 1'b0;
      STYLE_GCI_O            <= 1'b0;
    end else begin
      SLOW_CLOCK_OUT_O <= mclk_s ^ in_sel ^ out_sel;
      if (any_edge) begin
        FAST_CLOCK_OUT_O <= out_sel;
      end else if (mid_hit) begin
        FAST_CLOCK_OUT_O <= ~out_sel;
      end
      // Active level is the opposite of the detected idle level
      FRAME_PULSE_OUT_O      <= slow_act ^ idle_level_reg;
      FAST_FRAME_PULSE_OUT_O <= fast_act ^ idle_level_reg;
      FRAME_START_O          <= boundary;
      STYLE_GCI_O            <= ~idle_level_reg;
    end
  end

endmodule

// [test/tb.sv]
// Self-checking bench for the frame-timing front end
`timescale 1ns/1ps
module tb;
  localparam FC = 16;              // Short frame for simulation
  reg        ref_clk = 1'b0;       // Block clock
  reg        resetn = 1'b0;        // Reset, active low
  reg        isel, osel, wide, gci, run; // Source and edge settings
  wire       mclk, fpi, sclk, fpo, fclk, ffpo, fst, sty; // Pins
  integer    bad_count = 0;        // Mismatches
  integer    compares = 0;         // Comparisons made
  integer    i, k, w, fw, fc;      // Loop and width counters
  reg [12:0] rows [0:3];           // Settings, slow and fast widths
  always #50 ref_clk = ~ref_clk;
  tdm_timing_src #(.FRAME_CYCLES(FC)) src (.edge_i(isel), .wide_i(wide),
    .gci_i(gci), .run_i(run), .mclk_o(mclk), .fp_o(fpi));
  tdm_frame_timing_generator #(.FRAME_CYCLES(FC)) DUT (
    .REF_CLK_I(ref_clk), .RESETN_I(resetn),
    .MASTER_CLOCK_IN_I(mclk), .FRAME_PULSE_IN_I(fpi),
    .INPUT_EDGE_SELECT_I(isel), .OUTPUT_EDGE_SELECT_I(osel),
    .FRAME_PULSE_WIDTH_SELECT_I(wide), .SLOW_CLOCK_OUT_O(sclk),
    .FRAME_PULSE_OUT_O(fpo), .FAST_CLOCK_OUT_O(fclk),
    .FAST_FRAME_PULSE_OUT_O(ffpo), .FRAME_START_O(fst),
    .STYLE_GCI_O(sty));
  // ==========
  // Comparison and closing helpers
  task check(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  // Bounded wait, so a lost boundary cannot hang the run
  task wait_start;
    begin
      k = 0;
      while (fst !== 1'b1 && k < 400) begin
        @(negedge ref_clk);
        k = k + 1;
      end
      // A lost boundary counts as a mismatch
      if (k >= 400) begin
        check(fst, 8'h01);
      end
    end
  endtask
  task finish_test;
    begin
      if (bad_count == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Watchdog: about six times the expected run
  initial begin
    #1000000;
    bad_count = bad_count + 1;
    finish_test;
  end
  initial begin
    {isel, osel, wide, gci, run} = 5'h00;
    rows[0] = 13'h0084;
    rows[1] = 13'h1F08;
    rows[2] = 13'h0D08;
    rows[3] = 13'h1284;
    // Each row is set up in reset, so no edge select moves mid-frame
    for (i = 0; i < 4; i = i + 1) begin
      @(negedge ref_clk);
      resetn = 1'b0;
      run = 1'b0;
      {isel, osel, wide, gci} = rows[i][12:9];
      repeat (4) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (200) @(negedge ref_clk);
      check(sty, gci);
      run = 1'b1;
      wait_start;
      check({fpo, ffpo}, {gci, gci});
      check({sclk, fclk}, {osel, osel});
      w = 0;
      fw = 0;
      fc = 0;
      repeat (20) begin
        w = w + (fpo === gci);
        fw = fw + (ffpo === gci);
        fc = fc + (fclk === osel);
        @(negedge ref_clk);
      end
      check(w, rows[i][8:4]);
      check(fw, rows[i][3:0]);
      // Fast clock halves are two block cycles each: ten of twenty
      check(fc, 8'h0A);
      wait_start;
      check(20 + k, FC * 8);
    end
    // Source falls silent: framing carries on from the counter
    run = 1'b0;
    w = 0;
    fw = 0;
    repeat (150) begin
      @(negedge ref_clk);
      w = w + (fst === 1'b1);
      fw = fw + (fpo === gci);
    end
    check(w, 8'h00);
    check(fw, 8'h0F);
    // Reset in mid-run forces the idle outputs
    @(negedge ref_clk);
    resetn = 1'b0;
    @(negedge ref_clk);
    check({sclk, fclk, fpo, ffpo, fst, sty}, 6'h0C);
    finish_test;
  end
endmodule

// [test/tdm_timing_chk.sv]
// Port assertions for the frame-timing front end
`timescale 1ns/1ps
module tdm_timing_chk (
  input wire REF_CLK_I,                  // Block clock
  input wire RESETN_I,                   // Reset, active low
  input wire FRAME_PULSE_WIDTH_SELECT_I, // Width select pin
  input wire SLOW_CLOCK_OUT_O,           // Slow output clock
  input wire FRAME_PULSE_OUT_O,          // Slow output pulse
  input wire FAST_CLOCK_OUT_O,           // Fast output clock
  input wire FAST_FRAME_PULSE_OUT_O,     // Fast output pulse
  input wire FRAME_START_O,              // Boundary strobe
  input wire STYLE_GCI_O                 // Detected style
);
  // ==========
  // Active level of each pulse follows the learned style
  wire st   = FRAME_START_O;
  wire wd   = FRAME_PULSE_WIDTH_SELECT_I;
  wire act  = FRAME_PULSE_OUT_O == STYLE_GCI_O;
  wire fact = FAST_FRAME_PULSE_OUT_O == STYLE_GCI_O;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);
  property p_one; st |=> !st; endproperty
  a_one: assert property (p_one) else $error("strobe held");
  property p_act; st |-> act && fact; endproperty
  a_act: assert property (p_act) else $error("no pulse");
  property p_nar; st && !wd |-> act[*8] ##1 !act; endproperty
  a_nar: assert property (p_nar) else $error("narrow width");
  property p_wid; st && wd |-> act[*8] ##1 act[*8] ##1 !act; endproperty
  a_wid: assert property (p_wid) else $error("wide width");
  property p_fnar; st && !wd |-> fact[*4] ##1 !fact; endproperty
  a_fnar: assert property (p_fnar) else $error("fast narrow");
  property p_fwid; st && wd |-> fact[*8] ##1 !fact; endproperty
  a_fwid: assert property (p_fwid) else $error("fast wide");
  property p_sclk; $changed(SLOW_CLOCK_OUT_O) |=>
    $stable(SLOW_CLOCK_OUT_O) ##[1:4] $changed(SLOW_CLOCK_OUT_O); endproperty
  a_sclk: assert property (p_sclk) else $error("slow clock");
  property p_fclk; $changed(FAST_CLOCK_OUT_O) |->
    ##[1:4] $changed(FAST_CLOCK_OUT_O); endproperty
  a_fclk: assert property (p_fclk) else $error("fast clock");
endmodule
bind tdm_frame_timing_generator tdm_timing_chk u_chk (
  .REF_CLK_I                  (REF_CLK_I),
  .RESETN_I                   (RESETN_I),
  .FRAME_PULSE_WIDTH_SELECT_I (FRAME_PULSE_WIDTH_SELECT_I),
  .SLOW_CLOCK_OUT_O           (SLOW_CLOCK_OUT_O),
  .FRAME_PULSE_OUT_O          (FRAME_PULSE_OUT_O),
  .FAST_CLOCK_OUT_O           (FAST_CLOCK_OUT_O),
  .FAST_FRAME_PULSE_OUT_O     (FAST_FRAME_PULSE_OUT_O),
  .FRAME_START_O              (FRAME_START_O),
  .STYLE_GCI_O                (STYLE_GCI_O)
);

// [test/tdm_timing_src.sv]
// Behavioural timing source: master clock and input frame pulse
`timescale 1ns/1ps
module tdm_timing_src #(
  parameter FRAME_CYCLES = 16 // Master cycles per frame
) (
  input  wire edge_i, // Boundary edge, 1 rising
  input  wire wide_i, // Two-cycle pulse
  input  wire gci_i,  // Idle-low style
  input  wire run_i,  // Send pulses at all
  output reg  mclk_o, // Master clock
  output reg  fp_o    // Frame pulse
);
  integer cnt = 0; // Master cycle within frame
  // ==========
  // Clock runs free, also between frames
  initial mclk_o = 1'b0;
  initial fp_o = 1'b1;
  always #400 mclk_o = ~mclk_o;
  // Pulse moves on the other edge, so it is steady when sampled
  always @(mclk_o) begin
    if (mclk_o !== edge_i) begin
      cnt = (cnt + 1) % FRAME_CYCLES;
      fp_o = (run_i && cnt < (wide_i ? 2 : 1)) ^ !gci_i;
    end
  end
endmodule
